// ===== core/rsc_pkg.sv
/*
  Shared constants of the reset source controller: register map, field
  positions, reset values, reset source indices and release waits.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package rsc_pkg;

  // Clock rate
  localparam int unsigned MCLK_PERIOD_NS = 10;

  // Register byte addresses and bus width
  localparam int unsigned AXI_ADDR_W     = 8;
  localparam logic [7:0]  REG_FIRST      = 8'h00;
  localparam logic [7:0]  REG_SECOND     = 8'h04;
  localparam logic [7:0]  REG_THIRD      = 8'h08;
  localparam logic [7:0]  REG_MON_CTRL   = 8'h0C;
  localparam logic [7:0]  REG_LIVE       = 8'h10;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Field positions
  localparam int unsigned F1_POWER_ON    = 0;
  localparam int unsigned F1_MON_LO      = 1;
  localparam int unsigned F1_DEEP_STBY   = 4;
  localparam int unsigned F2_INDEP_WDOG  = 0;
  localparam int unsigned F2_WDOG        = 1;
  localparam int unsigned F2_SOFTWARE    = 2;
  localparam int unsigned F2_PERIPH      = 3;
  localparam int unsigned F3_COLD_WARM   = 0;
  localparam int unsigned FC_MODE_LO     = 0;
  localparam int unsigned FC_LEVEL_LO    = 8;

  // Values after power-on reset, and the highest level code
  localparam logic [4:0] FIRST_RST       = 5'h01;
  localparam logic [3:0] SECOND_RST      = 4'h0;
  localparam logic [2:0] MODE_RST        = 3'h0;
  localparam logic [5:0] LEVEL_RST       = 6'h00;
  localparam logic [1:0] LEVEL_MAX       = 2'h2;

  // Reset source indices
  localparam int unsigned NSRC           = 9;
  localparam int unsigned SRC_MON0       = 0;
  localparam int unsigned SRC_DSBY       = 3;
  localparam int unsigned SRC_SW         = 4;
  localparam int unsigned SRC_IWDT       = 5;
  localparam int unsigned SRC_WDT        = 6;
  localparam int unsigned SRC_PIN        = 7;
  localparam int unsigned SRC_PERIPH     = 8;

  // Release waits: least times, rounded up to whole cycles
  localparam int unsigned STAB_TIME_NS   = 1000;
  localparam int unsigned SW_HOLD_NS     = 300;
  localparam int unsigned WDOG_HOLD_NS   = 200;
  localparam int unsigned PIN_HOLD_NS    = 200;
  localparam int unsigned DSBY_WAIT_CLK  = 35;
  localparam int unsigned STAB_CYC =
    (STAB_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned SW_HOLD_CYC =
    (SW_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned WDOG_HOLD_CYC =
    (WDOG_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned PIN_HOLD_CYC =
    (PIN_HOLD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned DSBY_WAIT_CYC  = DSBY_WAIT_CLK;
  localparam int unsigned SRC_HOLD_CYC [NSRC] = '{
    STAB_CYC, STAB_CYC, STAB_CYC, DSBY_WAIT_CYC, SW_HOLD_CYC,
    WDOG_HOLD_CYC, WDOG_HOLD_CYC, PIN_HOLD_CYC, WDOG_HOLD_CYC};

endpackage : rsc_pkg

// ===== core/rsc_sync.sv
/*
  Three-stage synchroniser for asynchronous level inputs.
  Assumes the inputs are slow levels; a change is taken once the second
  and third stages agree.
*/
`timescale 1ns/1ps
module rsc_sync #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } rsc_sync_state_t;

  rsc_sync_state_t st;
  rsc_sync_state_t next_st;

  // Stage one feeds stage two only, never the compare
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.q;

endmodule : rsc_sync

// ===== core/rsc_hold.sv
/*
  Release-wait stretcher for one reset source.
  busy is high while req is high and for CYCLES-1 cycles after its last
  high cycle, so a one-cycle request gives exactly CYCLES busy cycles.
*/
`timescale 1ns/1ps
module rsc_hold #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic req,
  output logic      busy
);
  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

  if (CYCLES < 1) begin : g_bad
    $error("rsc_hold: CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } rsc_hold_state_t;

  rsc_hold_state_t st;
  rsc_hold_state_t next_st;

  // Reload while requested, then count down the wait
  always_comb begin
    next_st = st;
    if (req) begin
      next_st.cnt = LOAD;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = req | (st.cnt != '0);

endmodule : rsc_hold

// ===== core/rsc_top.sv
/*
  Reset source controller: merges reset sources into one internal reset,
  applies release waits, keeps cause flags and the cold/warm flag, and
  offers them over AXI4-Lite.
  Assumes RESET_N is the power-on reset, source requests other than the
  pin and the comparators come from logic on MCLK.
*/
// Function
// RULE_01: Three supply thresholds, interrupt or reset each
// RULE_02: Each channel picks one of three levels
// RULE_03: Monitor reset held for stabilization after recovery
// RULE_04: Monitoring off until option setting enables it
// RULE_05: Monitor reset sets its channel cause flag
// RULE_06: Standby cancel asserts reset, restarts oscillation
// RULE_07: Standby reset held 34-35 cycles after cancel
// RULE_08: Standby reset sets its cause flag
// RULE_09: Core reset request triggers software reset
// RULE_10: Software reset held for fixed interval
// RULE_11: Peripheral fault resets always enabled
// RULE_12: Cold/warm flag tells power-on from warm
// RULE_13: Only power-on reset clears cold/warm flag
// RULE_14: Writing one sets cold/warm, zero ignored
// RULE_15: Cause flags readable in two status registers
// RULE_16: Power-on sets cause flag, pin reset clears
// RULE_17: Independent watchdog reset sets its flag
// RULE_18: Watchdog reset sets its flag
// RULE_19: Reset pin low forces reset state
// RULE_20: Internal reset held while any source busy
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
#(
  parameter int unsigned NFAULT = 4
) (
  input  wire logic                  MCLK,
  input  wire logic                  RESET_N,
  input  wire logic                  EXT_RESET_PIN_N,
  input  wire logic [2:0]            MON_BELOW,
  input  wire logic [2:0]            OPTION_FUNCTION_SETTING_ONE,
  input  wire logic                  DEEP_STANDBY_CANCEL,
  input  wire logic                  CORE_SYSTEM_RESET_REQUEST,
  input  wire logic                  IWDT_RESET_REQ,
  input  wire logic                  WDT_RESET_REQ,
  input  wire logic [NFAULT-1:0]     PERIPH_FAULT,
  output logic                       INT_RESET_N,
  output logic                       OSC_RESTART,
  output logic [2:0]                 MON_IRQ,
  output logic [5:0]                 MON_LEVEL_SEL,
  input  wire logic [AXI_ADDR_W-1:0] AWADDR,
  input  wire logic                  AWVALID,
  output logic                       AWREADY,
  input  wire logic [31:0]           WDATA,
  input  wire logic [3:0]            WSTRB,
  input  wire logic                  WVALID,
  output logic                       WREADY,
  output logic [1:0]                 BRESP,
  output logic                       BVALID,
  input  wire logic                  BREADY,
  input  wire logic [AXI_ADDR_W-1:0] ARADDR,
  input  wire logic                  ARVALID,
  output logic                       ARREADY,
  output logic [31:0]                RDATA,
  output logic [1:0]                 RRESP,
  output logic                       RVALID,
  input  wire logic                  RREADY
);
  if (NFAULT < 1) begin : g_bad
    $error("rsc_top: NFAULT must be at least 1");
  end

  typedef struct packed {
    logic [4:0]            first;
    logic [3:0]            second;
    logic                  cold_warm;
    logic [2:0]            mode;
    logic [5:0]            level;
    logic [2:0]            opt_en;
    logic                  cap_done;
    logic                  int_rst_n;
    logic                  osc_restart;
    logic                  aw_got;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } rsc_top_state_t;

  rsc_top_state_t st;
  rsc_top_state_t next_st;
  logic [2:0]      below;
  logic            pin_n;
  logic [2:0]      mon_rst_req;
  logic [NSRC-1:0] src_req;
  logic [NSRC-1:0] src_busy;
  logic            wr_go;
  logic [31:0]     rd_word;
  logic            rd_ok;

  // Pin and comparators are asynchronous to MCLK
  rsc_sync #(
    .W       (4),
    .RST_VAL (4'h1)
  ) u_sync (
    .mclk    (MCLK),
    .reset_n (RESET_N),
    .d       ({MON_BELOW, EXT_RESET_PIN_N}),
    .q       ({below, pin_n})
  );

  // Interrupt or reset per channel, gated by the option setting
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      MON_IRQ[i]     = st.opt_en[i] & below[i] & ~st.mode[i]; // RULE_01
      mon_rst_req[i] = st.opt_en[i] & below[i] & st.mode[i];  // RULE_04
    end
  end

  // Source requests, one per release-wait stretcher
  assign src_req[2:0]      = mon_rst_req;            // RULE_01
  assign src_req[SRC_DSBY] = DEEP_STANDBY_CANCEL;    // RULE_06
  assign src_req[SRC_SW]   = CORE_SYSTEM_RESET_REQUEST; // RULE_09
  assign src_req[SRC_IWDT] = IWDT_RESET_REQ;
  assign src_req[SRC_WDT]  = WDT_RESET_REQ;
  assign src_req[SRC_PIN]  = ~pin_n;                 // RULE_19
  assign src_req[SRC_PERIPH] = |PERIPH_FAULT;        // RULE_11

  // Each source keeps reset asserted for its own release wait
  for (genvar g = 0; g < NSRC; g++) begin : g_hold
    rsc_hold #(
      .CYCLES  (SRC_HOLD_CYC[g])            // RULE_03 RULE_07 RULE_10
    ) u_hold (
      .mclk    (MCLK),
      .reset_n (RESET_N),
      .req     (src_req[g]),
      .busy    (src_busy[g])
    );
  end

  // Register read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (ARADDR)
      REG_FIRST:    rd_word[4:0] = st.first;      // RULE_15
      REG_SECOND:   rd_word[3:0] = st.second;     // RULE_15
      REG_THIRD:    rd_word[F3_COLD_WARM] = st.cold_warm; // RULE_12
      REG_MON_CTRL: begin
        rd_word[FC_MODE_LO +: 3]  = st.mode;
        rd_word[FC_LEVEL_LO +: 6] = st.level;
      end
      REG_LIVE:     rd_word[7:0] = {st.osc_restart, below,
                                    st.opt_en, ~st.int_rst_n};
      default:      rd_ok = 1'b0;
    endcase
  end

  assign wr_go = st.aw_got & st.w_got & ~st.bvalid;

  // Next-state logic: bus, flags, control
  always_comb begin
    next_st = st;

    // Option setting is caught once, after power-on release
    if (!st.cap_done) begin
      next_st.opt_en   = OPTION_FUNCTION_SETTING_ONE; // RULE_04
      next_st.cap_done = 1'b1;
    end

    // Write channels are taken independently, in either order
    if (AWVALID && AWREADY) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_st.w_got = 1'b1;
      next_st.wdata = WDATA;
      next_st.wstrb = WSTRB;
    end
    if (st.bvalid && BREADY) begin
      next_st.bvalid = 1'b0;
    end

    // Commit a write once address and data are both held
    if (wr_go) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      case (st.awaddr)
        REG_FIRST: begin
          // Write one to clear a cause flag
          if (st.wstrb[0]) begin
            next_st.first = st.first & ~st.wdata[4:0];
          end
        end
        REG_SECOND: begin
          if (st.wstrb[0]) begin
            next_st.second = st.second & ~st.wdata[3:0];
          end
        end
        REG_THIRD: begin
          if (st.wstrb[0] && st.wdata[F3_COLD_WARM]) begin
            next_st.cold_warm = 1'b1;                 // RULE_14
          end
        end
        REG_MON_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.mode = st.wdata[FC_MODE_LO +: 3];
          end
          // A reserved level code leaves that channel as it was
          for (int i = 0; i < 3; i++) begin
            if (st.wstrb[1] &&
                st.wdata[FC_LEVEL_LO + 2*i +: 2] <= LEVEL_MAX) begin
              next_st.level[2*i +: 2] =
                st.wdata[FC_LEVEL_LO + 2*i +: 2];     // RULE_02
            end
          end
        end
        REG_LIVE: begin
          next_st.bresp = RESP_OKAY;
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    // Reads: one outstanding, answered the cycle after address
    if (st.rvalid && RREADY) begin
      next_st.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Hardware sets come after software clears, so a set wins
    for (int i = 0; i < 3; i++) begin
      if (mon_rst_req[i]) begin
        next_st.first[F1_MON_LO + i] = 1'b1;          // RULE_05
      end
    end
    if (DEEP_STANDBY_CANCEL) begin
      next_st.first[F1_DEEP_STBY] = 1'b1;             // RULE_08
    end
    if (CORE_SYSTEM_RESET_REQUEST) begin
      next_st.second[F2_SOFTWARE] = 1'b1;
    end
    if (IWDT_RESET_REQ) begin
      next_st.second[F2_INDEP_WDOG] = 1'b1;           // RULE_17
    end
    if (WDT_RESET_REQ) begin
      next_st.second[F2_WDOG] = 1'b1;                 // RULE_18
    end
    if (|PERIPH_FAULT) begin
      next_st.second[F2_PERIPH] = 1'b1;
    end
    if (!pin_n) begin
      next_st.first[F1_POWER_ON] = 1'b0;              // RULE_16
    end

    // Oscillator restart pulse on standby cancel
    next_st.osc_restart = DEEP_STANDBY_CANCEL;        // RULE_06

    // Merged internal reset
    next_st.int_rst_n = ~(|src_busy);                 // RULE_20
  end

  // Power-on reset is the only reset of this state; INT_RESET_N does not clear it
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      st           <= '0;
      st.first     <= FIRST_RST;                      // RULE_16
      st.second    <= SECOND_RST;
      st.cold_warm <= 1'b0;                           // RULE_13
      st.mode      <= MODE_RST;
      st.level     <= LEVEL_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign INT_RESET_N   = st.int_rst_n;
  assign OSC_RESTART   = st.osc_restart;
  assign MON_LEVEL_SEL = st.level;
  assign AWREADY       = ~st.aw_got & ~st.bvalid;
  assign WREADY        = ~st.w_got & ~st.bvalid;
  assign BVALID        = st.bvalid;
  assign BRESP         = st.bresp;
  assign ARREADY       = ~st.rvalid;
  assign RVALID        = st.rvalid;
  assign RDATA         = st.rdata;
  assign RRESP         = st.rresp;

  // Interrupt mode never raises a monitor reset
  property p_mon_irq_only;
    @(posedge MCLK) disable iff (!RESET_N)
    MON_IRQ[1] && !st.first[F1_MON_LO + 1] |=>
      !st.first[F1_MON_LO + 1];
  endproperty
  a_mon_irq_only: assert property (p_mon_irq_only) // RULE_01
    else $error("monitor interrupt also raised a reset");

  // Monitor reset sets its flag and holds the internal reset
  property p_mon_flag;
    @(posedge MCLK) disable iff (!RESET_N)
    mon_rst_req[0] |=> st.first[F1_MON_LO] && !INT_RESET_N;
  endproperty
  a_mon_flag: assert property (p_mon_flag) // RULE_05
    else $error("monitor reset did not set flag or reset");

  // Monitoring stays quiet while the option setting disables it
  property p_mon_off;
    @(posedge MCLK) disable iff (!RESET_N)
    (st.cap_done && !st.opt_en[2]) |-> !MON_IRQ[2] && !src_req[2];
  endproperty
  a_mon_off: assert property (p_mon_off) // RULE_04
    else $error("disabled monitor channel became active");

  // Stabilization wait still running after recovery
  property p_mon_stab;
    @(posedge MCLK) disable iff (!RESET_N)
    $fell(mon_rst_req[0]) |-> src_busy[SRC_MON0] [*8];
  endproperty
  a_mon_stab: assert property (p_mon_stab) // RULE_03
    else $error("monitor reset released without stabilization");

  // Standby cancel holds reset through the full wait
  property p_dsby_wait;
    @(posedge MCLK) disable iff (!RESET_N)
    DEEP_STANDBY_CANCEL |-> ##34 src_busy[SRC_DSBY] ##1 !INT_RESET_N;
  endproperty
  a_dsby_wait: assert property (p_dsby_wait) // RULE_07
    else $error("standby reset released before wait elapsed");

  // Standby cancel sets flag and pulses oscillator restart
  property p_dsby_flag;
    @(posedge MCLK) disable iff (!RESET_N)
    DEEP_STANDBY_CANCEL |=> st.first[F1_DEEP_STBY] && OSC_RESTART;
  endproperty
  a_dsby_flag: assert property (p_dsby_flag) // RULE_08
    else $error("standby cancel missed flag or restart");

  // Core request gives a software reset held at least nine cycles
  property p_sw_reset;
    @(posedge MCLK) disable iff (!RESET_N)
    CORE_SYSTEM_RESET_REQUEST |=> st.second[F2_SOFTWARE] &&
      !INT_RESET_N ##1 !INT_RESET_N [*8];
  endproperty
  a_sw_reset: assert property (p_sw_reset) // RULE_10
    else $error("software reset not generated or held");

  // Cold/warm flag never falls after power-on
  property p_cold_warm_keep;
    @(posedge MCLK) disable iff (!RESET_N)
    st.cold_warm |=> st.cold_warm;
  endproperty
  a_cold_warm_keep: assert property (p_cold_warm_keep) // RULE_13
    else $error("cold/warm flag cleared without power-on");

  // Writing one to the cold/warm bit sets it
  property p_cold_warm_set;
    @(posedge MCLK) disable iff (!RESET_N)
    (wr_go && st.awaddr == REG_THIRD && st.wstrb[0] && st.wdata[0])
      |=> st.cold_warm;
  endproperty
  a_cold_warm_set: assert property (p_cold_warm_set) // RULE_14
    else $error("cold/warm write of one did not set flag");

  // Pin reset clears the power-on cause and resets the device
  property p_pin_reset;
    @(posedge MCLK) disable iff (!RESET_N)
    !pin_n |=> !st.first[F1_POWER_ON] && !INT_RESET_N;
  endproperty
  a_pin_reset: assert property (p_pin_reset) // RULE_16
    else $error("pin reset kept power-on flag or no reset");

  // Any busy source holds the merged reset one cycle later
  property p_merge;
    @(posedge MCLK) disable iff (!RESET_N)
    (|src_busy) |=> !INT_RESET_N;
  endproperty
  a_merge: assert property (p_merge) // RULE_20
    else $error("internal reset released while a source is busy");

endmodule : rsc_top

// ===== verification/rsc_partner.sv
/*
  Stand-in for the core, the supply comparators, the watchdogs, the reset
  pin and the peripheral fault sources facing the reset source controller.
  Assumes the bench raises fire bits by NBA just after a rising edge.
*/
`timescale 1ns/1ps
module rsc_partner
  import rsc_pkg::*;
(
  input  wire logic [NSRC-1:0] fire,
  input  wire logic [3:0]      fmask,
  output logic      [2:0]      below,
  output logic                 pin_n,
  output logic                 dsby_cancel,
  output logic                 core_req,
  output logic                 iwdt_req,
  output logic                 wdt_req,
  output logic      [3:0]      fault
);
  // Supply dips per channel, slow levels
  assign below       = fire[2:0];
  // Pin pulled high unless pressed
  assign pin_n       = !fire[SRC_PIN];
  assign dsby_cancel = fire[SRC_DSBY];
  // Level request: held high keeps the core in reset
  assign core_req    = fire[SRC_SW];
  assign iwdt_req    = fire[SRC_IWDT];
  assign wdt_req     = fire[SRC_WDT];
  // No enable exists for faults, so any mask bit resets
  assign fault       = fire[SRC_PERIPH] ? fmask : 4'h0;
endmodule : rsc_partner

// ===== verification/rsc_top_test.sv
/*
  Self-checking bench of the reset source controller: AXI4-Lite master,
  reset source stimulus through the partner, queued expectations.
  Assumes the 100 MHz MCLK and the register map of rsc_pkg.
*/
`timescale 1ns/1ps
module rsc_top_test
  import rsc_pkg::*;
;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [NSRC-1:0] fire = '0;
  logic [3:0] fmask = 4'h1;
  logic [2:0] OPTION_FUNCTION_SETTING_ONE = 3'h3;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'hF;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  logic EXT_RESET_PIN_N, DEEP_STANDBY_CANCEL, CORE_SYSTEM_RESET_REQUEST;
  logic IWDT_RESET_REQ, WDT_RESET_REQ, INT_RESET_N, OSC_RESTART;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [2:0] MON_BELOW, MON_IRQ;
  logic [3:0] PERIPH_FAULT;
  logic [5:0] MON_LEVEL_SEL;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic [33:0] exp_bus[$];
  int exp_len[$];
  int bad_count = 0, n_compared = 0, run = 0;
  logic armed = 1'b0;

  always #5 MCLK = !MCLK;

  rsc_partner far (.fire(fire), .fmask(fmask), .below(MON_BELOW),
    .pin_n(EXT_RESET_PIN_N), .dsby_cancel(DEEP_STANDBY_CANCEL),
    .core_req(CORE_SYSTEM_RESET_REQUEST), .iwdt_req(IWDT_RESET_REQ),
    .wdt_req(WDT_RESET_REQ), .fault(PERIPH_FAULT));

  rsc_top #(.NFAULT(4)) dut (.MCLK, .RESET_N, .EXT_RESET_PIN_N,
    .MON_BELOW, .OPTION_FUNCTION_SETTING_ONE, .DEEP_STANDBY_CANCEL,
    .CORE_SYSTEM_RESET_REQUEST, .IWDT_RESET_REQ, .WDT_RESET_REQ,
    .PERIPH_FAULT, .INT_RESET_N, .OSC_RESTART, .MON_IRQ, .MON_LEVEL_SEL,
    .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY);

  // One comparison, counted either way
  task automatic tally(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : tally

  task automatic cmp_bus(input logic [33:0] got);
    if (exp_bus.size() == 0) tally(got, ~got);
    else tally(got, exp_bus.pop_front());
  endtask : cmp_bus

  task automatic cmp_len(input int got);
    if (exp_len.size() == 0) tally(34'(got), ~34'(got));
    else tally(34'(got), 34'(exp_len.pop_front()));
  endtask : cmp_len

  task automatic cmp_sig(input logic [5:0] got, input logic [5:0] exp);
    tally(34'(got), 34'(exp));
  endtask : cmp_sig

  // Watcher at the falling edge, where bus and reset outputs are settled
  always @(negedge MCLK) begin
    if (BVALID && BREADY) cmp_bus({BRESP, 32'h0});
    if (RVALID && RREADY) cmp_bus({RRESP, RDATA});
    if (RESET_N && INT_RESET_N === 1'b1) begin
      if (run > 0) cmp_len(run);
      run = 0;
      armed = 1'b1;
    end else if (armed) begin
      run++;
    end
  end

  // Handshakes judged before the edge, released just after it
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    logic aw, w, b;
    exp_bus.push_back({r, 32'h0});
    b = 1'b0;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!b) begin
      @(negedge MCLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      @(posedge MCLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (b) BREADY <= 1'b0;
    end
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [1:0] r,
                     input logic [31:0] d);
    logic ar, rv;
    exp_bus.push_back({r, d});
    rv = 1'b0;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!rv) begin
      @(negedge MCLK);
      ar = ARVALID && ARREADY;
      rv = RVALID;
      @(posedge MCLK);
      if (ar) ARVALID <= 1'b0;
      if (rv) RREADY <= 1'b0;
    end
  endtask : axr

  // Source held h cycles; flag read back, then cleared by write-one
  task automatic src_run(input int idx, input int h, input int len,
    input logic [7:0] a, input logic [31:0] r, input logic [31:0] w);
    exp_len.push_back(len);
    @(posedge MCLK);
    fire[idx] <= 1'b1;
    repeat (h) @(posedge MCLK);
    fire[idx] <= 1'b0;
    if (idx == SRC_DSBY) begin
      @(negedge MCLK);
      cmp_sig(6'(OSC_RESTART), 6'h01);
    end
    repeat (4) @(posedge MCLK);
    for (int i = 0; i < 400 && INT_RESET_N !== 1'b1; i++) @(posedge MCLK);
    axr(a, RESP_OKAY, r);
    axw(a, w, RESP_OKAY);
  endtask : src_run

  task automatic final_report;
    if (exp_bus.size() + exp_len.size() > 0) bad_count++;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Watchdog: whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge MCLK);
    bad_count++;
    final_report();
  end

  initial begin
    void'($urandom(32'h49B3));
    repeat (8) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (8) @(posedge MCLK);
    axr(REG_FIRST, RESP_OKAY, 32'h01);
    axr(REG_SECOND, RESP_OKAY, 32'h0);
    axr(REG_THIRD, RESP_OKAY, 32'h0);
    axr(REG_MON_CTRL, RESP_OKAY, 32'h0);
    axr(REG_LIVE, RESP_OKAY, 32'h06);
    axr(8'h14, RESP_SLVERR, 32'h0);
    axw(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
    axw(REG_THIRD, 32'h0, RESP_OKAY);
    axr(REG_THIRD, RESP_OKAY, 32'h0);
    axw(REG_THIRD, 32'h1, RESP_OKAY);
    axr(REG_THIRD, RESP_OKAY, 32'h1);
    // Level code 3 on channel 2 must be ignored
    axw(REG_MON_CTRL, 32'h3601, RESP_OKAY);
    axr(REG_MON_CTRL, RESP_OKAY, 32'h0601);
    cmp_sig(MON_LEVEL_SEL, 6'h06);
    @(posedge MCLK);
    fire[2:1] <= 2'b11;
    repeat (6) @(posedge MCLK);
    cmp_sig(6'(MON_IRQ), 6'h02);
    fire[2:1] <= 2'b00;
    repeat (6) @(posedge MCLK);
    fmask <= 4'(($urandom % 15) + 1);
    src_run(SRC_DSBY, 1, 35, REG_FIRST, 32'h11, 32'h10);
    src_run(SRC_SW, 1, 30, REG_SECOND, 32'h4, 32'h4);
    src_run(SRC_SW, 5, 34, REG_SECOND, 32'h4, 32'h4);
    src_run(SRC_IWDT, 1, 20, REG_SECOND, 32'h1, 32'h1);
    src_run(SRC_WDT, 1, 20, REG_SECOND, 32'h2, 32'h2);
    src_run(SRC_PERIPH, 1, 20, REG_SECOND, 32'h8, 32'h8);
    src_run(SRC_MON0, 4, 103, REG_FIRST, 32'h03, 32'h02);
    src_run(SRC_PIN, 3, 22, REG_FIRST, 32'h0, 32'h0);
    axr(REG_THIRD, RESP_OKAY, 32'h1);
    repeat (4) @(posedge MCLK);
    final_report();
  end
endmodule : rsc_top_test
